// file: shared/dacci_defs.svh
// register offsets, field positions and reset values of the converter control block
// assumes an 8-bit special-function-register bus with direct 8-bit addresses
// How it works
// - 12-bit output updates on low byte write
// - bit 4 routes output to common pin
// - bit 3 gives 8-bit mode, LSBs zero
// - bit 2 selects supply or reference span
// - bit 1 low holds data registers cleared
// - bit 0 enables converter, else powered down
// - after reset converter off, output high-impedance
// - data registers reset zero, not bit addressable
// - control bits 7..5 unimplemented, writes ignored
`ifndef DACCI_DEFS_SVH
`define DACCI_DEFS_SVH
`define DACCI_ADDR_DATA_LOW 8'hFB
`define DACCI_ADDR_DATA_HIGH 8'hFC
`define DACCI_ADDR_CONTROL 8'hFD
`define DACCI_RESET_BYTE 8'h00
`define DACCI_CTRL_MASK 8'h1F
`define DACCI_BIT_PIN_SEL 4
`define DACCI_BIT_BYTE_RES 3
`define DACCI_BIT_RANGE 2
`define DACCI_BIT_CLEAR_N 1
`define DACCI_BIT_ENABLE 0
`define DACCI_NIBBLE_MASK 8'h0F
`define DACCI_LOW_PAD 4'h0
`define DACCI_NIBBLE_TOP 3
`define DACCI_RESET_BIT 1'b0
`endif

// file: shared/dacci_pkg.sv
// types shared by the converter control block
// assumes nothing beyond the defines header
package dacci_pkg;
    typedef logic [7:0] dacci_byte_t;
    typedef logic [11:0] dacci_code_t;
endpackage

// file: shared/dacci_code_if.sv
// carries the next data byte values and mode into the code formatter
// assumes both ends run on the same clock
interface dacci_code_if;
    logic [7:0] data_low;
    logic [7:0] data_high;
    logic byte_resolution_select;
    logic [11:0] code;
    modport source (output data_low, output data_high, output byte_resolution_select,
        input code);
    modport sink (input data_low, input data_high, input byte_resolution_select,
        output code);
endinterface

// file: core/dacci_code_fmt.sv
// forms the 12-bit converter code from the data bytes
// assumes bytes are the parent's next register values, settled before the edge
`include "dacci_defs.svh"
module dacci_code_fmt (
    dacci_code_if.sink link
);
    import dacci_pkg::*;
    // ------------------------------------------------------------
    // code selection
    // ------------------------------------------------------------
    wire [3:0] high_nibble = link.data_high[`DACCI_NIBBLE_TOP:0];
    wire [11:0] wide_code = {high_nibble, link.data_low};
    wire [11:0] byte_code = {link.data_low, `DACCI_LOW_PAD};
    assign link.code = link.byte_resolution_select ? byte_code : wide_code;
endmodule

// file: core/dacci_top.sv
// control and data registers for the on-chip voltage-output converter
// assumes a single-cycle special-function-register write/read port on core_clk_in
`include "dacci_defs.svh"
module dacci_top (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] sfr_addr_in,
    input wire dacci_pkg::dacci_byte_t sfr_wdata_in,
    input wire logic sfr_write_in,
    input wire logic sfr_read_in,
    output dacci_pkg::dacci_byte_t sfr_rdata_out,
    output logic sfr_hit_out,
    output dacci_pkg::dacci_code_t converter_code_out,
    output logic converter_enable_out,
    output logic output_drive_en_out,
    output logic output_pin_select_out,
    output logic analog_common_pin_en_out,
    output logic dedicated_pin_en_out,
    output logic output_range_select_out
);
    import dacci_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // true when a direct address names one register of this block
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    // unimplemented control bits are dropped on the way in, so they read as zero
    function automatic dacci_byte_t implemented_bits(input dacci_byte_t value);
        return value & `DACCI_CTRL_MASK;
    endfunction

    // a pin is driven only while the converter is powered and routed to it
    function automatic logic pin_drive(input logic powered, input logic to_common,
            input logic want_common);
        return powered && (to_common == want_common);
    endfunction

    // the code that a cleared or freshly reset converter holds
    function automatic dacci_code_t idle_code();
        return {`DACCI_RESET_BYTE, `DACCI_LOW_PAD};
    endfunction

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire hit_low = addr_is(sfr_addr_in, `DACCI_ADDR_DATA_LOW);
    wire hit_high = addr_is(sfr_addr_in, `DACCI_ADDR_DATA_HIGH);
    wire hit_ctrl = addr_is(sfr_addr_in, `DACCI_ADDR_CONTROL);
    wire hit_any = hit_low || hit_high || hit_ctrl;
    wire wr_low = sfr_write_in && hit_low;
    wire wr_high = sfr_write_in && hit_high;
    wire wr_ctrl = sfr_write_in && hit_ctrl;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    dacci_byte_t control;
    dacci_byte_t data_low;
    dacci_byte_t data_high;
    dacci_byte_t next_control;
    dacci_byte_t next_data_low;
    dacci_byte_t next_data_high;
    dacci_byte_t read_mux;
    dacci_code_t code_now;
    logic clear_now;
    logic code_load;
    logic next_enable;
    logic next_pin_select;
    logic next_range_select;
    logic next_common_en;
    logic next_dedicated_en;

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    assign next_control = wr_ctrl ? implemented_bits(sfr_wdata_in) : control;
    // clear follows the control value that stands after this edge, so a write
    // that drops the clear bit empties the data bytes in that same cycle
    assign clear_now = !next_control[`DACCI_BIT_CLEAR_N];
    // clear beats any data write; writes while cleared are lost
    assign next_data_low = clear_now ? `DACCI_RESET_BYTE :
        wr_low ? sfr_wdata_in : data_low;
    assign next_data_high = clear_now ? `DACCI_RESET_BYTE :
        wr_high ? sfr_wdata_in : data_high;
    // a high byte write alone never moves the code, so no half-updated value
    // reaches the converter; a control write re-forms the held bytes
    assign code_load = wr_low || wr_ctrl;

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // no bit addressing: only whole-byte writes exist on this port
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            control <= `DACCI_RESET_BYTE;
        end else begin
            control <= next_control;
        end
    end

    // ------------------------------------------------------------
    // data registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            data_low <= `DACCI_RESET_BYTE;
        end else begin
            data_low <= next_data_low;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            data_high <= `DACCI_RESET_BYTE;
        end else begin
            data_high <= next_data_high;
        end
    end

    // ------------------------------------------------------------
    // code formatting and output latch
    // ------------------------------------------------------------
    dacci_code_if code_link ();
    assign code_link.data_low = next_data_low;
    assign code_link.data_high = next_data_high;
    // the formatter sees the mode that stands after this edge
    assign code_link.byte_resolution_select = next_control[`DACCI_BIT_BYTE_RES];
    assign code_now = code_link.code;
    dacci_code_fmt u_fmt (
        .link(code_link.sink)
    );

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            converter_code_out <= idle_code();
        end else if (clear_now) begin
            converter_code_out <= idle_code();
        end else if (code_load) begin
            converter_code_out <= code_now;
        end
    end

    // ------------------------------------------------------------
    // output control
    // ------------------------------------------------------------
    // these come from flip-flops loaded with the next control value, so they
    // change at the same edge as the control register itself
    assign next_enable = next_control[`DACCI_BIT_ENABLE];
    assign next_pin_select = next_control[`DACCI_BIT_PIN_SEL];
    assign next_range_select = next_control[`DACCI_BIT_RANGE];
    assign next_common_en = pin_drive(next_enable, next_pin_select, 1'b1);
    assign next_dedicated_en = pin_drive(next_enable, next_pin_select, 1'b0);

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            converter_enable_out <= `DACCI_RESET_BIT;
        end else begin
            converter_enable_out <= next_enable;
        end
    end

    // the buffer leaves its pin floating until software powers the converter
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            output_drive_en_out <= `DACCI_RESET_BIT;
        end else begin
            output_drive_en_out <= next_enable;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            output_pin_select_out <= `DACCI_RESET_BIT;
        end else begin
            output_pin_select_out <= next_pin_select;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            analog_common_pin_en_out <= `DACCI_RESET_BIT;
        end else begin
            analog_common_pin_en_out <= next_common_en;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            dedicated_pin_en_out <= `DACCI_RESET_BIT;
        end else begin
            dedicated_pin_en_out <= next_dedicated_en;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            output_range_select_out <= `DACCI_RESET_BIT;
        end else begin
            output_range_select_out <= next_range_select;
        end
    end

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    assign sfr_hit_out = hit_any;
    // unmapped addresses read as zero; a read has no side effect on the code
    assign read_mux = hit_low ? data_low :
        hit_high ? data_high :
        hit_ctrl ? control : `DACCI_RESET_BYTE;

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            sfr_rdata_out <= `DACCI_RESET_BYTE;
        end else if (sfr_read_in) begin
            sfr_rdata_out <= read_mux;
        end
    end
endmodule

// file: verif/dacci_props.sv
// assertions on the converter control block ports
// assumes a bind into dacci_top and a single clock domain
`include "dacci_defs.svh"
module dacci_props (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic sfr_write_in,
    input wire logic sfr_read_in,
    input wire logic [7:0] sfr_addr_in,
    input wire dacci_pkg::dacci_byte_t sfr_wdata_in,
    input wire dacci_pkg::dacci_byte_t sfr_rdata_out,
    input wire dacci_pkg::dacci_code_t converter_code_out,
    input wire logic converter_enable_out,
    input wire logic output_drive_en_out,
    input wire logic output_pin_select_out,
    input wire logic analog_common_pin_en_out,
    input wire logic dedicated_pin_en_out,
    input wire logic output_range_select_out
);
    wire ctl_wr = sfr_write_in && sfr_addr_in == `DACCI_ADDR_CONTROL;
    wire code_wr = ctl_wr || (sfr_write_in && sfr_addr_in == `DACCI_ADDR_DATA_LOW);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    AST_START: assert property ($rose(reset_n_in) |->
        !converter_code_out && !converter_enable_out && !output_drive_en_out)
        else $error("not idle after reset");
    AST_HOLD: assert property (!code_wr |=> $stable(converter_code_out))
        else $error("code moved without a low or control write");
    AST_CTRL: assert property (ctl_wr |=>
        converter_enable_out == $past(sfr_wdata_in[`DACCI_BIT_ENABLE])
        && output_range_select_out == $past(sfr_wdata_in[`DACCI_BIT_RANGE]))
        else $error("enable or range wrong");
    AST_PIN: assert property (ctl_wr |=>
        output_pin_select_out == $past(sfr_wdata_in[`DACCI_BIT_PIN_SEL]))
        else $error("pin select wrong");
    AST_CLEAR: assert property (ctl_wr && !sfr_wdata_in[`DACCI_BIT_CLEAR_N] |=>
        converter_code_out == 12'h000) else $error("code not cleared");
    AST_ROUTE: assert property (
        analog_common_pin_en_out == (converter_enable_out && output_pin_select_out)
        && dedicated_pin_en_out == (converter_enable_out && !output_pin_select_out))
        else $error("routing wrong");
    AST_DRIVE: assert property (output_drive_en_out == converter_enable_out)
        else $error("drive enable differs from converter enable");
    AST_CTRL_RD: assert property (sfr_read_in && sfr_addr_in == `DACCI_ADDR_CONTROL |=>
        !sfr_rdata_out[7:5]) else $error("unused control bits read back");
endmodule
bind dacci_top dacci_props i_dacci_props (.*);

// file: verif/dacci_top_tb.sv
// random register traffic against an integer model of the converter block
// assumes registers update on the rising edge; inputs change on the falling edge
`include "dacci_defs.svh"
module dacci_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dacci_pkg::*;
    logic core_clk_in = 1'b0, reset_n_in = 1'b0, sfr_write_in = 1'b0, sfr_read_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00;
    dacci_byte_t sfr_wdata_in = 8'h00, sfr_rdata_out;
    dacci_code_t converter_code_out;
    logic sfr_hit_out, converter_enable_out, output_drive_en_out, output_pin_select_out;
    logic analog_common_pin_en_out, dedicated_pin_en_out, output_range_select_out;
    int fails = 0, comparisons = 0, ctl = 0, lo = 0, hi = 0, code = 0, rd = 0, hit = 0;
    bit [31:0] rng = 32'hBEDE;
    dacci_top i_dacci_top (.*);
    function automatic bit [31:0] xs(bit [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic chk(string n, int e, logic [11:0] g);
        comparisons++;
        if (g !== e[11:0]) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", n, e[11:0], g);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d, fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // compares every output with the model after the last rising edge
    task automatic check_all();
        chk("code", code, converter_code_out);
        chk("rdata", rd, {4'h0, sfr_rdata_out});
        chk("hit", hit, {11'h000, sfr_hit_out});
        chk("pins", {ctl[0], ctl[0], ctl[4], ctl[2], ctl[0] & ctl[4], ctl[0] & ~ctl[4]},
            {converter_enable_out, output_drive_en_out, output_pin_select_out,
            output_range_select_out, analog_common_pin_en_out,
            dedicated_pin_en_out});
    endtask
    // one bus cycle: check, drive the request, then model what the next edge does
    task automatic step(bit wr, logic [7:0] a, logic [7:0] d);
        @(negedge core_clk_in);
        check_all();
        sfr_addr_in = a;
        sfr_wdata_in = d;
        sfr_write_in = wr;
        sfr_read_in = !wr;
        hit = a inside {`DACCI_ADDR_DATA_LOW, `DACCI_ADDR_DATA_HIGH, `DACCI_ADDR_CONTROL};
        // clear wins over data writes
        if (wr) begin
            if (a == `DACCI_ADDR_DATA_LOW && ctl[1]) lo = d;
            if (a == `DACCI_ADDR_DATA_HIGH && ctl[1]) hi = d;
            if (a == `DACCI_ADDR_CONTROL) ctl = d % 32;
            lo = ctl[1] ? lo : 0;
            hi = ctl[1] ? hi : 0;
            if (a == `DACCI_ADDR_DATA_LOW || a == `DACCI_ADDR_CONTROL)
                code = ctl[3] ? lo * 16 : hi % 16 * 256 + lo;
        end else begin
            rd = a == `DACCI_ADDR_DATA_LOW ? lo : a == `DACCI_ADDR_DATA_HIGH ? hi :
                a == `DACCI_ADDR_CONTROL ? ctl : 0;
        end
    endtask
    initial begin
        forever #20 core_clk_in = ~core_clk_in;
    end
    initial begin
        repeat (3) @(negedge core_clk_in);
        reset_n_in = 1'b1;
        repeat (3000) begin
            rng = xs(rng);
            step(rng[2], rng[1:0] == 2'h3 ? rng[15:8] : `DACCI_ADDR_DATA_LOW + rng[1:0],
                rng[23:16]);
        end
        step(1'b1, `DACCI_ADDR_CONTROL, 8'hE3);
        step(1'b1, `DACCI_ADDR_DATA_HIGH, 8'hFA);
        step(1'b1, `DACCI_ADDR_DATA_LOW, 8'hBC);
        step(1'b0, `DACCI_ADDR_CONTROL, 8'h00);
        step(1'b1, `DACCI_ADDR_CONTROL, 8'h1B);
        step(1'b1, `DACCI_ADDR_CONTROL, 8'h05);
        step(1'b0, `DACCI_ADDR_DATA_LOW, 8'h00);
        // reset again in mid-run: everything must fall back to idle
        @(negedge core_clk_in);
        check_all();
        reset_n_in = 1'b0;
        sfr_write_in = 1'b0;
        sfr_read_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
        reset_n_in = 1'b1;
        ctl = 0;
        lo = 0;
        hi = 0;
        code = 0;
        rd = 0;
        step(1'b0, `DACCI_ADDR_DATA_HIGH, 8'h00);
        step(1'b0, `DACCI_ADDR_CONTROL, 8'h00);
        step(1'b0, `DACCI_ADDR_DATA_LOW, 8'h00);
        complete_run();
    end
endmodule
